/* File: urm_pkg.sv */
package urm_pkg;
   localparam logic [4:0] ADDR_MAX = 5'h19;
   localparam logic [4:0] ADDR_PROFILE_6 = 5'h14;
   localparam logic [4:0] ADDR_PROFILE_7 = 5'h15;
   localparam logic [4:0] ADDR_RAM_WORD = 5'h16;
   localparam logic [4:0] ADDR_GPIO_DIR = 5'h18;
   localparam logic [4:0] ADDR_GPIO_VAL = 5'h19;
   localparam logic [63:0] PROFILE_RESET = 64'h0;
   localparam logic [31:0] RAM_WORD_RESET = 32'h0;
   localparam logic [15:0] GPIO_RESET = 16'h0;
   // single-tone profile field positions
   localparam int ST_ASF_HI = 61;
   localparam int ST_ASF_LO = 48;
   localparam int POW_HI = 47;
   localparam int POW_LO = 32;
   localparam int FTW_HI = 31;
   localparam int FTW_LO = 0;
   // quadrature profile field positions
   localparam int QD_RATE_HI = 63;
   localparam int QD_RATE_LO = 58;
   localparam int QD_INVERT = 57;
   localparam int QD_BYPASS = 56;
   localparam int QD_OSF_HI = 55;
   localparam int QD_OSF_LO = 48;

   typedef struct packed {
      logic [63:0] profile_6;
      logic [63:0] profile_7;
      logic [31:0] ram_word;
      logic [15:0] gpio_dir;
      logic [15:0] gpio_val;
   } urm_regs_t;

   typedef struct packed {
      logic [13:0] amp_scale;
      logic [15:0] phase_offset;
      logic [31:0] freq_tuning;
   } urm_tone_t;

   typedef struct packed {
      logic [5:0] interp_rate;
      logic spectral_invert;
      logic interp_comb_filter_bypass;
      logic [7:0] out_scale;
      logic [15:0] phase_offset;
      logic [31:0] freq_tuning;
   } urm_quad_t;

   typedef struct packed {
      urm_regs_t stage;
      urm_regs_t active;
      logic [2:0] profile_sel;
   } urm_state_t;
endpackage

/* File: urm_regmap.sv */
`timescale 1ns/1ns
`default_nettype none
// How it works
// - decode addresses 0x00 to 0x19 only
// - twenty registers; listed gaps unimplemented
// - each register has its own byte length
// - staged writes go live on update/profile change
// - bit zero is least significant bit
// - profile 7 single-tone amplitude, phase, frequency
// - quadrature top byte: rate, invert, bypass
// - RAM word, GPIO config and data registers
module urm_regmap (
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic [4:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic [63:0] REG_WDATA,
   output logic [63:0] REG_RDATA,
   output logic [3:0] REG_NBYTES,
   input wire logic IO_UPDATE,
   input wire logic [2:0] PROFILE,
   input wire logic [19:0] LOW_RDATA,
   output logic [63:0] PROFILE_6_ACT,
   output logic [63:0] PROFILE_7_ACT,
   output urm_pkg::urm_tone_t PROFILE_7_TONE,
   output urm_pkg::urm_quad_t PROFILE_7_QUAD,
   output urm_pkg::urm_quad_t PROFILE_6_QUAD,
   output logic [31:0] RAM_WORD,
   output logic [15:0] GPIO_DIR,
   output logic [15:0] GPIO_VAL
);
   urm_pkg::urm_state_t st_r;
   urm_pkg::urm_state_t st_nxt;
   logic [2:0] prof_s1_r;
   logic [2:0] prof_s2_r;
   logic upd_s1_r;
   logic upd_s2_r;
   logic upd_old_r;
   logic go_live;

   // byte length per address, zero where unused
   function automatic logic [3:0] nbytes(input logic [4:0] a);
      logic [3:0] n;
      n = 4'h0;
      if (a > urm_pkg::ADDR_MAX) begin
         n = 4'h0;
      end else if (a == 5'h07 || a == 5'h08 || a == 5'h17 ||
         (a >= 5'h0b && a <= 5'h0d)) begin
         n = 4'h0;
      end else if (a >= 5'h0e && a <= urm_pkg::ADDR_PROFILE_7) begin
         n = 4'h8;
      end else if (a == urm_pkg::ADDR_GPIO_DIR ||
         a == urm_pkg::ADDR_GPIO_VAL) begin
         n = 4'h2;
      end else begin
         n = 4'h4;
      end
      return n;
   endfunction

   // pin-side inputs synchronised
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         prof_s1_r <= 3'h0;
         prof_s2_r <= 3'h0;
         upd_s1_r <= 1'h0;
         upd_s2_r <= 1'h0;
         upd_old_r <= 1'h0;
      end else begin
         prof_s1_r <= PROFILE;
         prof_s2_r <= prof_s1_r;
         upd_s1_r <= IO_UPDATE;
         upd_s2_r <= upd_s1_r;
         upd_old_r <= upd_s2_r;
      end
   end

   assign go_live = (upd_s2_r && !upd_old_r) ||
      (prof_s2_r != st_r.profile_sel);

   always_comb begin
      st_nxt = st_r;
      st_nxt.profile_sel = prof_s2_r;
      if (REG_WR) begin
         case (REG_ADDR)
            urm_pkg::ADDR_PROFILE_6: begin
               st_nxt.stage.profile_6 = REG_WDATA;
            end
            urm_pkg::ADDR_PROFILE_7: begin
               st_nxt.stage.profile_7 = REG_WDATA;
            end
            urm_pkg::ADDR_RAM_WORD: begin
               st_nxt.stage.ram_word = REG_WDATA[31:0];
            end
            urm_pkg::ADDR_GPIO_DIR: begin
               st_nxt.stage.gpio_dir = REG_WDATA[15:0];
            end
            urm_pkg::ADDR_GPIO_VAL: begin
               st_nxt.stage.gpio_val = REG_WDATA[15:0];
            end
            default: begin
               st_nxt.stage = st_nxt.stage;
            end
         endcase
      end
      if (go_live) begin
         st_nxt.active = st_nxt.stage;
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         st_r.stage.profile_6 <= urm_pkg::PROFILE_RESET;
         st_r.stage.profile_7 <= urm_pkg::PROFILE_RESET;
         st_r.stage.ram_word <= urm_pkg::RAM_WORD_RESET;
         st_r.stage.gpio_dir <= urm_pkg::GPIO_RESET;
         st_r.stage.gpio_val <= urm_pkg::GPIO_RESET;
         st_r.active.profile_6 <= urm_pkg::PROFILE_RESET;
         st_r.active.profile_7 <= urm_pkg::PROFILE_RESET;
         st_r.active.ram_word <= urm_pkg::RAM_WORD_RESET;
         st_r.active.gpio_dir <= urm_pkg::GPIO_RESET;
         st_r.active.gpio_val <= urm_pkg::GPIO_RESET;
         st_r.profile_sel <= 3'h0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // readback of staged values, LOW_RDATA for used addresses below 0x14, zero where unused
   always_comb begin
      REG_NBYTES = nbytes(REG_ADDR);
      case (REG_ADDR)
         urm_pkg::ADDR_PROFILE_6: begin
            REG_RDATA = st_r.stage.profile_6;
         end
         urm_pkg::ADDR_PROFILE_7: begin
            REG_RDATA = st_r.stage.profile_7;
         end
         urm_pkg::ADDR_RAM_WORD: begin
            REG_RDATA = {32'h0, st_r.stage.ram_word};
         end
         urm_pkg::ADDR_GPIO_DIR: begin
            REG_RDATA = {48'h0, st_r.stage.gpio_dir};
         end
         urm_pkg::ADDR_GPIO_VAL: begin
            REG_RDATA = {48'h0, st_r.stage.gpio_val};
         end
         default: begin
            REG_RDATA = 64'h0;
            if (nbytes(REG_ADDR) != 4'h0) begin
               REG_RDATA = {44'h0, LOW_RDATA};
            end
         end
      endcase
   end

   // field views, bit zero the lsb
   assign PROFILE_6_ACT = st_r.active.profile_6;
   assign PROFILE_7_ACT = st_r.active.profile_7;
   assign PROFILE_7_TONE.amp_scale =
      st_r.active.profile_7[urm_pkg::ST_ASF_HI:urm_pkg::ST_ASF_LO];
   assign PROFILE_7_TONE.phase_offset =
      st_r.active.profile_7[urm_pkg::POW_HI:urm_pkg::POW_LO];
   assign PROFILE_7_TONE.freq_tuning =
      st_r.active.profile_7[urm_pkg::FTW_HI:urm_pkg::FTW_LO];
   assign PROFILE_7_QUAD = st_r.active.profile_7;
   assign PROFILE_6_QUAD = st_r.active.profile_6;
   assign RAM_WORD = st_r.active.ram_word;
   assign GPIO_DIR = st_r.active.gpio_dir;
   assign GPIO_VAL = st_r.active.gpio_val;
endmodule
`default_nettype wire

/* File: urm_host.sv */
`timescale 1ns/1ns
`default_nettype none
module urm_host (
   input wire logic MCLK,
   output logic [4:0] REG_ADDR,
   output logic REG_WR,
   output logic [63:0] REG_WDATA
);
   initial begin
      REG_ADDR = 5'h00;
      REG_WR = 1'b0;
      REG_WDATA = 64'h0;
   end
   task automatic wr(input logic [4:0] a, input logic [63:0] d,
                     input logic [3:0] n);
      @(posedge MCLK);
      REG_ADDR <= a;
      REG_WDATA <= d & ((64'h1 << {n, 3'h0}) - 64'h1);
      REG_WR <= 1'b1;
      @(posedge MCLK);
      REG_WR <= 1'b0;
      REG_WDATA <= ~d;
   endtask
   task automatic rd(input logic [4:0] a);
      @(posedge MCLK);
      REG_ADDR <= a;
      #10;
   endtask
endmodule
`default_nettype wire

/* File: urm_regmap_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module urm_regmap_chk (
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic [4:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic [63:0] REG_WDATA,
   input wire logic [63:0] REG_RDATA,
   input wire logic [3:0] REG_NBYTES,
   input wire logic IO_UPDATE,
   input wire logic [2:0] PROFILE,
   input wire logic [63:0] PROFILE_6_ACT,
   input wire logic [63:0] PROFILE_7_ACT,
   input wire urm_pkg::urm_tone_t PROFILE_7_TONE,
   input wire urm_pkg::urm_quad_t PROFILE_7_QUAD,
   input wire logic [15:0] GPIO_VAL
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RST_N);
   a_gap_zero: assert property (REG_ADDR inside {5'h07, 5'h08,
      [5'h0b:5'h0d], 5'h17} |-> REG_RDATA == 64'h0 && REG_NBYTES == 4'h0)
      else $error("gap address not empty");
   a_range_end: assert property (REG_ADDR > 5'h19 |->
      REG_RDATA == 64'h0 && REG_NBYTES == 4'h0) else $error("out of range");
   a_len_profile: assert property (REG_ADDR inside {[5'h0e:5'h15]}
      |-> REG_NBYTES == 4'h8) else $error("profile length wrong");
   a_len_gpio: assert property (REG_ADDR inside {5'h18, 5'h19}
      |-> REG_NBYTES == 4'h2) else $error("gpio length wrong");
   a_gpio_read: assert property (REG_WR && REG_ADDR == 5'h19 ##1
      REG_ADDR == 5'h19 |-> REG_RDATA == {48'h0, $past(REG_WDATA[15:0])})
      else $error("gpio readback wrong");
   a_stage_hold: assert property ((!IO_UPDATE && $stable(PROFILE))[*5]
      |=> $stable({GPIO_VAL, PROFILE_6_ACT, PROFILE_7_ACT}))
      else $error("active value moved without update");
   a_update_live: assert property ($rose(IO_UPDATE) ##0
      (REG_ADDR == 5'h19 && !REG_WR)[*5] |-> GPIO_VAL == REG_RDATA[15:0])
      else $error("update did not go live");
   a_field_map: assert property (PROFILE_7_TONE == PROFILE_7_ACT[61:0] &&
      PROFILE_7_QUAD == PROFILE_7_ACT) else $error("profile fields wrong");
endmodule
bind urm_regmap urm_regmap_chk urm_regmap_chk_i (.*);
`default_nettype wire

/* File: urm_regmap_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module urm_regmap_tb;
   typedef struct packed {
      logic [4:0] a;
      logic [63:0] d;
      logic [63:0] e;
      logic [3:0] n;
   } urm_row_t;
   logic MCLK, RST_N, IO_UPDATE, REG_WR;
   logic [2:0] PROFILE;
   logic [4:0] REG_ADDR;
   logic [3:0] REG_NBYTES;
   logic [63:0] REG_WDATA, REG_RDATA, p6, p7;
   logic [31:0] RAM_WORD;
   logic [15:0] GPIO_DIR, GPIO_VAL;
   urm_pkg::urm_tone_t tone;
   urm_pkg::urm_quad_t q6, q7;
   int n_errors, checks;
   urm_row_t rows[8] = '{
      '{5'h14, 64'hfedcba9876543210, 64'hfedcba9876543210, 4'h8},
      '{5'h15, 64'h3b5c123489abcdef, 64'h3b5c123489abcdef, 4'h8},
      '{5'h16, 64'hdeadbeef, 64'hdeadbeef, 4'h4},
      '{5'h18, 64'h0f0f, 64'h0f0f, 4'h2},
      '{5'h19, 64'h1234, 64'h1234, 4'h2},
      '{5'h07, '1, 64'h0, 4'h0},
      '{5'h17, '1, 64'h0, 4'h0},
      '{5'h1a, '1, 64'h0, 4'h0}};
   urm_host urm_host_i (.MCLK(MCLK), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
      .REG_WDATA(REG_WDATA));
   urm_regmap urm_regmap_i (.MCLK(MCLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
      .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
      .REG_NBYTES(REG_NBYTES), .IO_UPDATE(IO_UPDATE), .PROFILE(PROFILE),
      .LOW_RDATA(20'h0), .PROFILE_6_ACT(p6), .PROFILE_7_ACT(p7),
      .PROFILE_7_TONE(tone), .PROFILE_7_QUAD(q7), .PROFILE_6_QUAD(q6),
      .RAM_WORD(RAM_WORD), .GPIO_DIR(GPIO_DIR), .GPIO_VAL(GPIO_VAL));
   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic live(input logic pin);
      @(posedge MCLK);
      IO_UPDATE <= pin;
      if (!pin) PROFILE <= 3'h5;
      @(posedge MCLK);
      IO_UPDATE <= 1'b0;
      repeat (6) @(posedge MCLK);
      #10;
   endtask
   initial begin
      MCLK = 0;
      forever #50 MCLK = ~MCLK;
   end
   initial begin
      #100000;
      n_errors++;
      tally_and_finish;
   end
   initial begin
      {RST_N, IO_UPDATE, PROFILE} = '0;
      repeat (12) @(posedge MCLK);
      RST_N <= 1'b1;
      urm_host_i.rd(5'h19);
      chk(REG_RDATA | GPIO_VAL | p7, 64'h0);
      foreach (rows[i]) urm_host_i.wr(rows[i].a, rows[i].d,
         rows[i].n == 4'h0 ? 4'h8 : rows[i].n);
      foreach (rows[i]) begin
         urm_host_i.rd(rows[i].a);
         chk(REG_RDATA, rows[i].e);
         chk(REG_NBYTES, rows[i].n);
      end
      chk(p6 | GPIO_VAL, 64'h0);
      urm_host_i.rd(5'h19);
      live(1'b1);
      chk(p6, rows[0].d);
      chk(p7, rows[1].d);
      chk({RAM_WORD, GPIO_DIR, GPIO_VAL}, 64'hdeadbeef0f0f1234);
      chk({tone.amp_scale, q7.interp_rate, q7.spectral_invert,
         q7.interp_comb_filter_bypass, q6.interp_rate}, {14'h3b5c, 6'h0e,
         2'h3, 6'h3f});
      urm_host_i.wr(5'h19, 64'h00a5, 4'h2);
      live(1'b0);
      chk(GPIO_VAL, 64'h00a5);
      RST_N <= 1'b0;
      #10;
      chk(REG_RDATA | GPIO_VAL | p6, 64'h0);
      tally_and_finish;
   end
endmodule
`default_nettype wire
